// ===== udic_pkg.sv
// Constants for the USB device interrupt control block: register offsets,
// bit positions, reset values and timing counts.
// Assumes a 100 MHz peripheral clock and word-wide AHB-Lite accesses.
package udic_pkg;

  // Register offsets (byte addresses within the block)
  localparam logic [11:0] OFF_ENABLE = 12'h010;
  localparam logic [11:0] OFF_DISABLE = 12'h014;
  localparam logic [11:0] OFF_MASK = 12'h018;
  localparam logic [11:0] OFF_STATUS = 12'h01C;
  localparam logic [11:0] OFF_CLEAR = 12'h020;

  // Bit positions shared by enable, disable, mask, status and clear
  localparam int unsigned EP_COUNT = 4;
  localparam int unsigned BIT_SUSPEND = 8;
  localparam int unsigned BIT_RESUME = 9;
  localparam int unsigned BIT_FRAME = 11;
  localparam int unsigned BIT_BUSRST = 12;
  localparam int unsigned BIT_WAKEUP = 13;

  localparam logic [31:0] MASKABLE_BITS = 32'h0000_2B0F;
  localparam logic [31:0] CLEARABLE_BITS = 32'h0000_3B00;
  localparam logic [31:0] UNMASKABLE_BITS = 32'h0000_1000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0200;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // Idle time before suspend
  localparam int unsigned SUSPEND_IDLE_US = 3000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned IDLE_CNT_W = 19;

  // Indices into the synchronised USB-domain input vector
  localparam int unsigned SYN_W = 4;
  localparam int unsigned SYN_ACTIVE = 0;
  localparam int unsigned SYN_RESUME = 1;
  localparam int unsigned SYN_FRAME = 2;
  localparam int unsigned SYN_BUSRST = 3;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic {udic_st_active, udic_st_suspended} udic_state_t;

endpackage : udic_pkg

// ===== udic_top.sv
// Interrupt enable, disable, mask, status and clear logic of a full-speed
// USB device port, reached over an AHB-Lite slave port.
// Assumes endpoint flags come from logic on hclk; bus_active, resume_signal,
// frame_start_toggle and bus_reset_active come from the USB clock domain.
//
// Contract
// - Enable write of one to endpoint bits 0-3 sets those mask bits.
// - Enable write sets suspend, resume, frame and wakeup mask bits 8,9,11,13.
// - Disable write of one to an endpoint bit clears that mask bit.
// - Disable write clears suspend, resume, frame, wakeup mask bits likewise.
// - Mask register reads one for each enabled source, zero otherwise.
// - Mask bit 12 always reads one; bus-reset-done cannot be masked.
// - Resume mask bit is enabled out of reset.
// - Endpoint status is high while any of its five flags is set.
// - Endpoint status stays until the flag clears; clear register has none.
// - After 3 ms bus idle, set suspend status and enter suspend mode.
// - Resume signalling on the bus sets the resume status bit.
// - Every start-of-frame token sets the frame status bit.
// - Bus reset completion sets bus-reset-done; firmware readies endpoint 0.
// - Host resume or reset sets wakeup status; firmware clears it after reset.
// - Clear register ones clear suspend, resume, frame, bus-reset, wakeup status.
`timescale 1ns/100ps

module udic_top
  import udic_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = SUSPEND_IDLE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [EP_COUNT-1:0] setup_received_flag,
  input wire logic [EP_COUNT-1:0] bank0_received_flag,
  input wire logic [EP_COUNT-1:0] bank1_received_flag,
  input wire logic [EP_COUNT-1:0] transmit_done_flag,
  input wire logic [EP_COUNT-1:0] stall_acknowledged_flag,
  input wire logic bus_active,
  input wire logic resume_signal,
  input wire logic frame_start_toggle,
  input wire logic bus_reset_active,
  output logic irq,
  output logic suspended
);

  localparam logic [IDLE_CNT_W-1:0] IDLE_LAST = IDLE_CNT_W'(IDLE_CYCLES - 1);

  function automatic logic [31:0] onehot(input int unsigned pos, input logic ev);
    onehot = ev ? (32'h0000_0001 << pos) : 32'h0000_0000;
  endfunction : onehot

  // USB-domain inputs: three stages, filtered value follows once stages 2 and 3 agree
  logic [SYN_W-1:0] sync1;
  logic [SYN_W-1:0] sync2;
  logic [SYN_W-1:0] sync3;
  logic [SYN_W-1:0] filt;
  logic [SYN_W-1:0] filt_d;
  logic [SYN_W-1:0] next_filt;
  logic [SYN_W-1:0] usb_in;

  assign usb_in = {bus_reset_active, frame_start_toggle, resume_signal, bus_active};

  always_comb begin
    next_filt = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
      filt_d <= '0;
    end else begin
      sync1 <= usb_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      filt_d <= filt;
    end
  end

  logic resume_evt;
  logic frame_evt;
  logic busrst_start_evt;
  logic busrst_done_evt;
  logic suspend_evt;

  assign resume_evt = filt[SYN_RESUME] & ~filt_d[SYN_RESUME];
  // The frame line toggles once per token, so either edge is one frame
  assign frame_evt = filt[SYN_FRAME] ^ filt_d[SYN_FRAME];
  assign busrst_start_evt = filt[SYN_BUSRST] & ~filt_d[SYN_BUSRST];
  assign busrst_done_evt = ~filt[SYN_BUSRST] & filt_d[SYN_BUSRST];

  // Suspend detection
  udic_state_t state;
  udic_state_t next_state;
  logic [IDLE_CNT_W-1:0] idle_count;
  logic [IDLE_CNT_W-1:0] next_idle_count;

  always_comb begin
    next_state = state;
    next_idle_count = idle_count;
    suspend_evt = 1'b0;
    if (filt[SYN_ACTIVE]) begin
      next_idle_count = '0;
    end else if (idle_count != IDLE_LAST) begin
      next_idle_count = idle_count + IDLE_CNT_W'(1);
    end
    case (state)
      udic_st_active: begin
        if (!filt[SYN_ACTIVE] && idle_count == IDLE_LAST) begin
          suspend_evt = 1'b1;
          next_state = udic_st_suspended;
        end
      end
      udic_st_suspended: begin
        if (filt[SYN_ACTIVE] || resume_evt || busrst_start_evt) begin
          next_state = udic_st_active;
        end
      end
      default: begin
        next_state = udic_st_active;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= udic_st_active;
      idle_count <= '0;
    end else begin
      state <= next_state;
      idle_count <= next_idle_count;
    end
  end

  assign suspended = (state == udic_st_suspended);

  // AHB-Lite slave: zero wait states, writes land in the data phase
  logic wr_pend;
  logic [11:0] wr_addr;
  logic [31:0] next_hrdata;
  logic next_wr_pend;
  logic [11:0] next_wr_addr;
  logic addr_take;
  logic wr_fire;

  logic [31:0] mask;
  logic [31:0] next_mask;
  logic [31:0] mask_view;
  logic [31:0] status_reg;
  logic [31:0] next_status;
  logic [31:0] status_view;
  logic [31:0] set_evts;
  logic [EP_COUNT-1:0] ep_any;
  logic next_irq;
  // Sources that are both raised and enabled; any one drives the interrupt
  logic [31:0] pending;

  assign addr_take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
  assign wr_fire = wr_pend;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  // Endpoint bits are live views of the endpoint flags, so they clear only
  // when firmware clears the flag in the endpoint's own register
  assign ep_any = setup_received_flag | bank0_received_flag | bank1_received_flag
                  | transmit_done_flag | stall_acknowledged_flag;
  assign status_view = (status_reg & CLEARABLE_BITS) | {28'h000_0000, ep_any};
  assign mask_view = (mask & MASKABLE_BITS) | UNMASKABLE_BITS;
  assign pending = status_view & mask_view;

  always_comb begin
    next_wr_pend = addr_take && hwrite;
    next_wr_addr = haddr[11:0];
    next_hrdata = 32'h0000_0000;
    if (addr_take && !hwrite) begin
      case (haddr[11:0])
        OFF_MASK: next_hrdata = mask_view;
        OFF_STATUS: next_hrdata = status_view;
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_mask = mask;
    if (wr_fire && wr_addr == OFF_ENABLE) begin
      next_mask = mask | (hwdata & MASKABLE_BITS);
    end else if (wr_fire && wr_addr == OFF_DISABLE) begin
      next_mask = mask & ~(hwdata & MASKABLE_BITS);
    end
  end

  always_comb begin
    set_evts = onehot(BIT_SUSPEND, suspend_evt)
               | onehot(BIT_RESUME, resume_evt)
               | onehot(BIT_FRAME, frame_evt)
               | onehot(BIT_BUSRST, busrst_done_evt)
               | onehot(BIT_WAKEUP, resume_evt | busrst_start_evt);
    next_status = status_reg;
    if (wr_fire && wr_addr == OFF_CLEAR) begin
      next_status = status_reg & ~(hwdata & CLEARABLE_BITS);
    end
    // An event in the cycle of its clear survives the clear
    next_status = next_status | set_evts;
    next_irq = |pending;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata <= 32'h0000_0000;
      mask <= MASK_RESET;
      status_reg <= STATUS_RESET;
      irq <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      mask <= next_mask;
      status_reg <= next_status;
      irq <= next_irq;
    end
  end

  enable_sets_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_fire && wr_addr == OFF_ENABLE)
    |=> ((mask_view & $past(hwdata) & MASKABLE_BITS) == ($past(hwdata) & MASKABLE_BITS))
  ) else $error("enable write did not set mask bits");

  disable_clears_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_fire && wr_addr == OFF_DISABLE) |=> ((mask_view & $past(hwdata) & MASKABLE_BITS) == 0)
  ) else $error("disable write did not clear mask bits");

  mask_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && haddr[11:0] == OFF_MASK)
    |=> (hrdata[BIT_BUSRST] && hrdata == $past(mask_view))
  ) else $error("mask read lost bit 12 or mismatched");

  ep_status_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && haddr[11:0] == OFF_STATUS)
    |=> (hrdata[EP_COUNT-1:0] == $past(ep_any))
  ) else $error("endpoint status does not follow its flags");

  suspend_entry_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state == udic_st_active && !filt[SYN_ACTIVE] && idle_count == IDLE_LAST)
    |=> (status_reg[BIT_SUSPEND] && suspended)
  ) else $error("idle timeout did not suspend");

  resume_sets_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(filt[SYN_RESUME]) |=> (status_reg[BIT_RESUME] && status_reg[BIT_WAKEUP])
  ) else $error("resume did not set resume and wakeup");

  frame_sets_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (filt[SYN_FRAME] != filt_d[SYN_FRAME]) |=> status_reg[BIT_FRAME]
  ) else $error("frame token missed");

  busrst_done_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(filt[SYN_BUSRST]) |=> status_reg[BIT_BUSRST]
  ) else $error("bus reset end not flagged");

  clear_works_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_fire && wr_addr == OFF_CLEAR && hwdata[BIT_FRAME] && !frame_evt)
    |=> !status_reg[BIT_FRAME]
  ) else $error("clear write left frame status set");

  irq_follows_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 (irq == ($past(pending) != 32'h0000_0000))
  ) else $error("interrupt output disagrees with status and mask");

  suspend_exit_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state == udic_st_suspended && filt[SYN_ACTIVE]) |=> !suspended
  ) else $error("bus activity did not end suspend mode");

  busrst_unmasked_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    status_reg[BIT_BUSRST] |=> irq
  ) else $error("bus reset done status did not raise the interrupt");

endmodule : udic_top

// ===== udic_host_model.sv
// Behavioural USB host side: bus activity, resume, frame tokens, bus reset.
// Assumes its task is called just after a rising hclk edge.
`timescale 1ns/100ps
module udic_host_model (
  input wire logic hclk,
  output logic bus_active,
  output logic resume_signal,
  output logic frame_start_toggle,
  output logic bus_reset_active
);
  initial begin
    bus_active = 1'b1;
    resume_signal = 1'b0;
    frame_start_toggle = 1'b0;
    bus_reset_active = 1'b0;
  end
  // Levels last 6 cycles, three times what the synchroniser needs to accept them
  task automatic pulse(input int k);
    case (k)
      0: frame_start_toggle <= ~frame_start_toggle;
      1: resume_signal <= 1'b1;
      2: bus_reset_active <= 1'b1;
      3: bus_active <= 1'b0;
      default: bus_active <= 1'b1;
    endcase
    repeat (6) @(posedge hclk);
    resume_signal <= 1'b0;
    bus_reset_active <= 1'b0;
  endtask : pulse
endmodule : udic_host_model

// ===== udic_top_tb.sv
// Self-checking bench for udic_top: mask registers, endpoint flags, bus events.
// Assumes a single AHB-Lite slave, so hready loops back from hreadyout.
`timescale 1ns/100ps
module udic_top_tb;
  import udic_pkg::*;
  localparam logic [31:0] EVT [3] = '{32'h0000_0800, 32'h0000_2200, 32'h0000_3000};
  localparam int CLR [5] = '{8, 11, 9, 12, 13};
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, suspended;
  logic [31:0] haddr, hwdata, hrdata, rd, wd, mv, ev;
  logic [1:0] htrans;
  logic [2:0] hsize, bsz;
  logic [EP_COUNT-1:0] fs, f0, f1, ft, fk;
  logic bact, rsig, ftog, brst;
  int n_fail, samples_checked;
  assign hready = hreadyout;
  udic_host_model host (.hclk(hclk), .bus_active(bact), .resume_signal(rsig),
    .frame_start_toggle(ftog), .bus_reset_active(brst));
  udic_top #(.IDLE_CYCLES(20)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .setup_received_flag(fs), .bank0_received_flag(f0), .bank1_received_flag(f1),
    .transmit_done_flag(ft), .stall_acknowledged_flag(fk), .bus_active(bact),
    .resume_signal(rsig), .frame_start_toggle(ftog), .bus_reset_active(brst),
    .irq(irq), .suspended(suspended));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask : chk
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= bsz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    // Idle cycle so a following read sees the completed write
    @(posedge hclk);
  endtask : bus
  function automatic logic [31:0] st_exp();
    logic [31:0] v;
    v = ev;
    for (int i = 0; i < EP_COUNT; i++) v[i] = fs[i] | f0[i] | f1[i] | ft[i] | fk[i];
    return v;
  endfunction : st_exp
  task automatic chk_st;
    repeat (2) @(posedge hclk);
    bus(OFF_STATUS, 1'b0, 32'h0000_0000);
    chk("status", st_exp(), rd);
    chk("irq", {31'h0, |(st_exp() & mv)}, {31'h0, irq});
  endtask : chk_st
  initial begin
    // Tests need under a thousand cycles; 20000 leaves ample margin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    n_fail = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    bsz = HSIZE_WORD;
    hwdata = 32'h0000_0000;
    {fs, f0, f1, ft, fk} = 20'h0_0000;
    ev = 32'h0000_0000;
    mv = 32'h0000_1200;
    rd = $urandom(32'h075d_4011);
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(OFF_MASK, 1'b0, 32'h0000_0000);
    chk("mask reset", 32'h0000_1200, rd);
    bus(OFF_CLEAR, 1'b1, CLEARABLE_BITS);
    chk_st();
    $display("test reset done");
    repeat (24) begin
      rd = $urandom & $urandom & $urandom;
      {fs, f0, f1, ft, fk} <= rd[19:0];
      wd = $urandom;
      if (wd[31]) begin
        bus(OFF_ENABLE, 1'b1, wd);
        mv = mv | (wd & MASKABLE_BITS);
      end else begin
        bus(OFF_DISABLE, 1'b1, wd);
        mv = mv & ~(wd & MASKABLE_BITS);
      end
      bus(OFF_MASK, 1'b0, 32'h0000_0000);
      chk("mask", mv, rd);
      bus(OFF_CLEAR, 1'b1, 32'h0000_000F);
      chk_st();
    end
    bus(OFF_DISABLE, 1'b1, 32'hFFFF_FFFF);
    bus(OFF_MASK, 1'b0, 32'h0000_0000);
    chk("mask none", 32'h0000_1000, rd);
    bus(OFF_ENABLE, 1'b1, 32'hFFFF_FFFF);
    mv = 32'h0000_3B0F;
    bus(OFF_MASK, 1'b0, 32'h0000_0000);
    chk("mask all", mv, rd);
    {fs, f0, f1, ft, fk} <= 20'h0_0050;
    chk_st();
    ft <= 4'h0;
    chk_st();
    $display("test masks and endpoints done");
    host.pulse(3);
    for (int i = 0; i < 200 && suspended !== 1'b1; i++) @(posedge hclk);
    ev[BIT_SUSPEND] = 1'b1;
    chk("suspended", 32'h1, {31'h0, suspended});
    host.pulse(4);
    repeat (10) @(posedge hclk);
    chk("awake", 32'h0, {31'h0, suspended});
    chk_st();
    for (int k = 0; k < 3; k++) begin
      host.pulse(k);
      repeat (10) @(posedge hclk);
      ev = ev | EVT[k];
      chk_st();
    end
    for (int i = 0; i < 5; i++) begin
      bus(OFF_CLEAR, 1'b1, 32'h0000_0001 << CLR[i]);
      ev[CLR[i]] = 1'b0;
      chk_st();
    end
    $display("test bus events done");
    bus(12'h024, 1'b0, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    bus(OFF_ENABLE, 1'b0, 32'h0000_0000);
    chk("write only", 32'h0000_0000, rd);
    // Non-word transfers are ignored: no mask change, reads return zero
    bsz = 3'h0;
    bus(OFF_DISABLE, 1'b1, 32'hFFFF_FFFF);
    bus(OFF_MASK, 1'b0, 32'h0000_0000);
    chk("byte read", 32'h0000_0000, rd);
    bsz = HSIZE_WORD;
    bus(OFF_MASK, 1'b0, 32'h0000_0000);
    chk("byte write", mv, rd);
    $display("test address map done");
    report_and_stop();
  end
endmodule : udic_top_tb
